// ### pkg/timer_pkg.sv
// package: register map, field layout, reset values and timing for the period timer
package timer_pkg;
  // register byte addresses on the apb bus
  localparam logic [11:0] ADDR_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_COUNT = 12'h004;
  localparam logic [11:0] ADDR_PERIOD = 12'h008;
  localparam logic [11:0] ADDR_FLAGS = 12'h00c;
  localparam logic [11:0] ADDR_ENABLES = 12'h010;
  localparam logic [11:0] ADDR_MISC = 12'h014;
  // control field positions
  localparam int CTL_PRE_LSB = 0;
  localparam int CTL_RUN_BIT = 2;
  localparam int CTL_POST_LSB = 3;
  // flag and enable bit positions
  localparam int FLAG_MATCH_BIT = 0;
  localparam int EN_MATCH_BIT = 0;
  localparam int MISC_SPI_BIT = 0;
  // reset values
  localparam logic [6:0] CONTROL_RESET = 7'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'hff;
  // instruction clock is one quarter of the oscillator rate
  localparam int OSC_PER_INSTR = 4;
  localparam logic [1:0] INSTR_DIV_LAST = 2'(OSC_PER_INSTR - 1);
  // prescale terminal counts for codes 00, 01, 10, 11
  localparam logic [5:0] PRE_LAST_1 = 6'h00;
  localparam logic [5:0] PRE_LAST_4 = 6'h03;
  localparam logic [5:0] PRE_LAST_16 = 6'h0f;
  localparam logic [5:0] PRE_LAST_64 = 6'h3f;

  // control register image
  typedef struct packed {
    logic [3:0] postscale_select;
    logic timer_run;
    logic [1:0] prescale_select;
  } timer_control_t;

  // apb request bundle
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
endpackage

// ### tb/period_timer_postscaler_chk.sv
// checker: bus and timer timing properties seen at the block ports
`timescale 1ns/1ps
module period_timer_postscaler_chk (
  // bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // timer
  input wire logic sleep,
  input wire logic match_pulse,
  input wire logic spi_shift_clock,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // bus answer shape
  property p_ready_second;
    psel && penable && !pready && !$past(penable) |=> pready;
  endproperty
  property p_ready_one;
    pready |=> !pready;
  endproperty
  property p_err_ready;
    pslverr |-> pready && psel && penable;
  endproperty
  property p_rdata_hold;
    pready |-> $stable(prdata);
  endproperty
  // timer outputs
  property p_pulse_gap;
    match_pulse |=> !match_pulse [*3];
  endproperty
  property p_sleep_quiet;
    sleep && $past(sleep) |=> !match_pulse;
  endproperty
  property p_spi_cause;
    $changed(spi_shift_clock) |-> match_pulse || $past(match_pulse);
  endproperty
  property p_irq_cause;
    $rose(irq) |-> match_pulse || $past(pready) || $past(pready, 2);
  endproperty
  a_ready_second: assert property (p_ready_second) else $error("late ready");
  a_ready_one: assert property (p_ready_one) else $error("long ready");
  a_err_ready: assert property (p_err_ready) else $error("stray error");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  a_pulse_gap: assert property (p_pulse_gap) else $error("pulses too close");
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("pulse in sleep");
  a_spi_cause: assert property (p_spi_cause) else $error("spi clock moved");
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
  c_match: cover property (match_pulse);
  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
endmodule

bind period_timer_postscaler period_timer_postscaler_chk i_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sleep(sleep), .match_pulse(match_pulse),
  .spi_shift_clock(spi_shift_clock), .irq(irq));

// ### tb/period_timer_postscaler_test.sv
// testbench: registers, scalers, flag, interrupt, sleep and run checks
`timescale 1ns/1ps
module period_timer_postscaler_test;
  import timer_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic sleep = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, a;
  logic pready, pslverr, match_pulse, spi_shift_clock, irq, err, s;
  int errors = 0;
  int checks_done = 0;
  int n;
  // clock
  always #25 pclk = ~pclk;
  period_timer_postscaler i_period_timer_postscaler (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep(sleep),
    .match_pulse(match_pulse), .spi_shift_clock(spi_shift_clock), .irq(irq));
  // verdict
  task automatic test_done;
    if (errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one bus transfer, held until ready
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      errors++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask
  task automatic rdchk(input logic [11:0] ad, input logic [31:0] e);
    apb(1'b0, ad, 32'h0);
    cmp(rd, e);
  endtask
  // cycles from one match pulse to the next
  task automatic gap(output int c);
    int k;
    k = 0;
    while (match_pulse !== 1'b1 && k < 3000) begin
      @(posedge pclk);
      k++;
    end
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (match_pulse !== 1'b1 && c < 3000);
    if (k >= 3000 || c >= 3000) begin
      errors++;
      test_done();
    end
  endtask
  task automatic t_reset;
    rdchk(ADDR_CONTROL, 32'h0);
    rdchk(ADDR_COUNT, 32'h0);
    rdchk(ADDR_PERIOD, 32'h0000_00ff);
    wr(ADDR_CONTROL, 32'hff);
    rdchk(ADDR_CONTROL, 32'h7f);
    rdchk(12'h020, 32'h0);
    cmp({31'h0, err}, 32'h1);
  endtask
  task automatic t_prescale;
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CONTROL, 32'h0);
      wr(ADDR_PERIOD, 32'h3);
      wr(ADDR_COUNT, 32'h0);
      wr(ADDR_CONTROL, 32'(4 + c));
      gap(n);
      cmp(32'(n), 32'(16 << (2 * c)));
    end
  endtask
  task automatic t_post;
    wr(ADDR_ENABLES, 32'h1);
    wr(ADDR_PERIOD, 32'h0);
    for (int p = 0; p < 16; p++) begin
      wr(ADDR_CONTROL, 32'h0);
      wr(ADDR_FLAGS, 32'h0);
      wr(ADDR_CONTROL, 32'(p * 8 + 4));
      n = 0;
      for (int k = 0; k < 3000 && irq !== 1'b1; k++) begin
        @(posedge pclk);
        if (match_pulse === 1'b1) n++;
      end
      cmp(32'(n), 32'(p + 1));
    end
    wr(ADDR_CONTROL, 32'h0);
    wr(ADDR_FLAGS, 32'h1);
    rdchk(ADDR_FLAGS, 32'h1);
    wr(ADDR_ENABLES, 32'h0);
    repeat (2) @(posedge pclk);
    cmp({31'h0, irq}, 32'h0);
    wr(ADDR_ENABLES, 32'h1);
    repeat (2) @(posedge pclk);
    cmp({31'h0, irq}, 32'h1);
    wr(ADDR_FLAGS, 32'h0);
    rdchk(ADDR_FLAGS, 32'h0);
  endtask
  task automatic t_freeze;
    wr(ADDR_PERIOD, 32'hff);
    wr(ADDR_CONTROL, 32'h4);
    repeat (40) @(posedge pclk);
    sleep <= 1'b1;
    apb(1'b0, ADDR_COUNT, 32'h0);
    a = rd;
    repeat (40) @(posedge pclk);
    rdchk(ADDR_COUNT, a);
    rdchk(ADDR_PERIOD, 32'hff);
    sleep <= 1'b0;
    repeat (40) @(posedge pclk);
    apb(1'b0, ADDR_COUNT, 32'h0);
    cmp({31'h0, rd !== a}, 32'h1);
    wr(ADDR_CONTROL, 32'h0);
    apb(1'b0, ADDR_COUNT, 32'h0);
    a = rd;
    repeat (40) @(posedge pclk);
    rdchk(ADDR_COUNT, a);
  endtask
  // period zero at prescale 1 gives one match every four clocks
  task automatic t_spi;
    wr(ADDR_MISC, 32'h1);
    wr(ADDR_PERIOD, 32'h0);
    wr(ADDR_CONTROL, 32'h4);
    gap(n);
    cmp(32'(n), 32'h4);
    s = spi_shift_clock;
    repeat (4) @(posedge pclk);
    cmp({31'h0, spi_shift_clock ^ s}, 32'h1);
    wr(ADDR_MISC, 32'h0);
    @(posedge pclk);
    s = spi_shift_clock;
    repeat (8) @(posedge pclk);
    cmp({31'h0, spi_shift_clock ^ s}, 32'h0);
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_prescale();
    t_post();
    t_freeze();
    t_spi();
    test_done();
  end
endmodule

// ### verilog/period_timer_postscaler.sv
// period timer with prescaler, period compare, postscaler and apb registers
`timescale 1ns/1ps
module period_timer_postscaler (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // processor state
  input wire logic sleep,
  // timer outputs
  output logic match_pulse,
  output logic spi_shift_clock,
  output logic irq
);
  import timer_pkg::*;

  timer_control_t ctl_q;
  logic [7:0] count_q;
  logic [7:0] period_q;
  logic match_flag_q;
  logic match_irq_enable_q;
  logic spi_select_q;
  logic [1:0] instr_div_q;
  logic spi_toggle_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic match_pulse_q;
  logic irq_q;
  apb_req_t req;
  logic wr_access;
  logic rd_setup;
  logic wr_ctl;
  logic wr_count;
  logic wr_period;
  logic wr_flags;
  logic wr_en;
  logic wr_misc;
  logic scaler_clear;
  logic instr_tick;
  logic pre_tick;
  logic cmp_equal;
  logic match_now;
  logic post_event;

  // gather the bus request
  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

  // address decode, used for write strobes and the unmapped-address error check
  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ref_addr);
    addr_is = (a == ref_addr);
  endfunction

  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = addr_is(a, ADDR_CONTROL) || addr_is(a, ADDR_COUNT) ||
                  addr_is(a, ADDR_PERIOD) || addr_is(a, ADDR_FLAGS) ||
                  addr_is(a, ADDR_ENABLES) || addr_is(a, ADDR_MISC);
  endfunction

  // a write takes effect in the access cycle while pready is high
  assign wr_access = req.psel && req.penable && req.pwrite && pready_q;
  assign rd_setup = req.psel && !req.penable && !req.pwrite;
  assign wr_ctl = wr_access && addr_is(req.paddr, ADDR_CONTROL);
  assign wr_count = wr_access && addr_is(req.paddr, ADDR_COUNT);
  assign wr_period = wr_access && addr_is(req.paddr, ADDR_PERIOD);
  assign wr_flags = wr_access && addr_is(req.paddr, ADDR_FLAGS);
  assign wr_en = wr_access && addr_is(req.paddr, ADDR_ENABLES);
  assign wr_misc = wr_access && addr_is(req.paddr, ADDR_MISC);
  assign scaler_clear = wr_ctl || wr_count;

  // apb ready: one wait state, answer in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= req.psel && req.penable && !pready_q;
    end
  end

  // error on unmapped address, raised with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= req.psel && req.penable && !pready_q && !addr_mapped(req.paddr);
    end
  end

  // read data captured during setup, stable through the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (rd_setup) begin
      case (req.paddr)
        ADDR_CONTROL: prdata_q <= {25'h0000000, ctl_q};
        ADDR_COUNT: prdata_q <= {24'h000000, count_q};
        ADDR_PERIOD: prdata_q <= {24'h000000, period_q};
        ADDR_FLAGS: prdata_q <= {31'h00000000, match_flag_q};
        ADDR_ENABLES: prdata_q <= {31'h00000000, match_irq_enable_q};
        ADDR_MISC: prdata_q <= {31'h00000000, spi_select_q};
        default: prdata_q <= 32'h00000000;
      endcase
    end
  end

  // control register, all bits zero after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= CONTROL_RESET;
    end else if (wr_ctl) begin
      ctl_q.postscale_select <= req.pwdata[CTL_POST_LSB +: 4];
      ctl_q.timer_run <= req.pwdata[CTL_RUN_BIT];
      ctl_q.prescale_select <= req.pwdata[CTL_PRE_LSB +: 2];
    end
  end

  // interrupt enable and spi clock source select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_irq_enable_q <= 1'b0;
      spi_select_q <= 1'b0;
    end else begin
      if (wr_en) begin
        match_irq_enable_q <= req.pwdata[EN_MATCH_BIT];
      end
      if (wr_misc) begin
        spi_select_q <= req.pwdata[MISC_SPI_BIT];
      end
    end
  end

  // instruction clock enable, one pulse per four oscillator cycles, frozen in sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_div_q <= 2'h0;
    end else if (!sleep) begin
      instr_div_q <= (instr_div_q == INSTR_DIV_LAST) ? 2'h0 : instr_div_q + 2'h1;
    end
  end

  assign instr_tick = !sleep && (instr_div_q == INSTR_DIV_LAST) && ctl_q.timer_run;

  prescaler i_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .tick_in(instr_tick),
    .clear(scaler_clear),
    .prescale_select(ctl_q.prescale_select),
    .tick_out(pre_tick)
  );

  // compare every cycle; the match acts on a prescaled tick
  assign cmp_equal = (count_q == period_q);
  assign match_now = pre_tick && cmp_equal;

  // count register: up from zero, frozen in sleep or when stopped
  // the tick that sees count equal to period reloads zero, so a period p lasts p+1 ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= COUNT_RESET;
    end else if (wr_count) begin
      count_q <= req.pwdata[7:0];
    end else if (pre_tick) begin
      count_q <= match_now ? 8'h00 : count_q + 8'h01;
    end
  end

  // period register, all ones after reset, unaffected by sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_q <= PERIOD_RESET;
    end else if (wr_period) begin
      period_q <= req.pwdata[7:0];
    end
  end

  postscaler i_postscaler (
    .pclk(pclk),
    .presetn(presetn),
    .match(match_now),
    .clear(scaler_clear),
    .postscale_select(ctl_q.postscale_select),
    .event_out(post_event)
  );

  // latched match flag; a new event wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_flag_q <= 1'b0;
    end else if (post_event) begin
      match_flag_q <= 1'b1;
    end else if (wr_flags && !req.pwdata[FLAG_MATCH_BIT]) begin
      match_flag_q <= 1'b0;
    end
  end

  // registered outputs: match pulse, spi shift clock, interrupt request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_pulse_q <= 1'b0;
      spi_toggle_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      match_pulse_q <= match_now;
      if (match_now && spi_select_q) begin
        spi_toggle_q <= !spi_toggle_q;
      end
      irq_q <= (match_flag_q || post_event) && match_irq_enable_q;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign match_pulse = match_pulse_q;
  assign spi_shift_clock = spi_toggle_q;
  assign irq = irq_q;
endmodule

// ### verilog/postscaler.sv
// postscaler: counts match pulses and fires one event every n+1 of them
`timescale 1ns/1ps
module postscaler (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic match,
  input wire logic clear,
  input wire logic [3:0] postscale_select,
  // event pulse
  output logic event_out
);
  logic [3:0] cnt_q;

  // the event occurs on the match that completes the ratio
  assign event_out = match && !clear && (cnt_q >= postscale_select);

  // 4-bit match counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
    end else if (clear) begin
      cnt_q <= 4'h0;
    end else if (match) begin
      cnt_q <= (cnt_q >= postscale_select) ? 4'h0 : cnt_q + 4'h1;
    end
  end
endmodule

// ### verilog/prescaler.sv
// prescaler: divides the instruction enable by 1, 4, 16 or 64
`timescale 1ns/1ps
module prescaler (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic tick_in,
  input wire logic clear,
  input wire logic [1:0] prescale_select,
  // output enable pulse
  output logic tick_out
);
  import timer_pkg::*;

  logic [5:0] cnt_q;
  logic [5:0] last;

  // terminal count of the selected ratio
  function automatic logic [5:0] pre_last(input logic [1:0] sel);
    case (sel)
      2'h0: pre_last = PRE_LAST_1;
      2'h1: pre_last = PRE_LAST_4;
      2'h2: pre_last = PRE_LAST_16;
      default: pre_last = PRE_LAST_64;
    endcase
  endfunction

  assign last = pre_last(prescale_select);
  assign tick_out = tick_in && !clear && (cnt_q >= last);

  // divider counter, cleared by control or count writes and reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 6'h00;
    end else if (clear) begin
      cnt_q <= 6'h00;
    end else if (tick_in) begin
      cnt_q <= (cnt_q >= last) ? 6'h00 : cnt_q + 6'h01;
    end
  end
endmodule
